//--- design/psg_pkg.sv
package psg_pkg;

  // frame layout: data, register address, chip address, shifted msb first
  localparam int          FRAME_BITS   = 32;
  localparam int          DATA_W       = 24;
  localparam int          REG_ADDR_W   = 5;
  localparam int          CHIP_ADDR_W  = 3;
  localparam int          CNT_W        = 6;
  localparam int          NUM_REGS     = 32;
  localparam int          CHIP_LSB     = 0;
  localparam int          REG_LSB      = 3;
  localparam int          DATA_LSB     = 8;

  // bit counter marks
  localparam logic [5:0]  CNT_ZERO     = 6'h00;
  localparam logic [5:0]  CNT_ONE      = 6'h01;
  localparam logic [5:0]  CNT_CHIP_LO  = 6'h1D;
  localparam logic [5:0]  CNT_CHIP_HI  = 6'h1F;
  localparam logic [5:0]  CNT_FULL     = 6'h20;
  localparam logic [5:0]  CNT_OVER     = 6'h21;

  localparam logic [2:0]  CHIP_ADDR_SELF = 3'h0;

  // register addresses
  localparam logic [4:0]  REG_IDENT    = 5'h00;
  localparam logic [4:0]  REG_CHIP_EN  = 5'h01;
  localparam logic [4:0]  REG_REFDIV   = 5'h02;
  localparam logic [4:0]  REG_INT      = 5'h03;
  localparam logic [4:0]  REG_DRV_CTRL = 5'h08;
  localparam logic [4:0]  REG_GPO_CTRL = 5'h0F;

  // field positions
  localparam int          PTR_MSB      = 4;
  localparam int          SOFT_RST_BIT = 5;
  localparam int          DRV_EN_BIT   = 5;
  localparam int          SEL_MSB      = 4;
  localparam int          FORCE_BIT    = 6;
  localparam int          HOLD_BIT     = 7;
  localparam int          PU_DIS_BIT   = 8;
  localparam int          PD_DIS_BIT   = 9;

  // reset values
  localparam logic [23:0] RST_CHIP_EN  = 24'h00_0003;
  localparam logic [23:0] RST_REFDIV   = 24'h00_0001;
  localparam logic [23:0] RST_INT      = 24'h00_0019;
  localparam logic [23:0] RST_DRV_CTRL = 24'h00_0020;
  localparam logic [23:0] RST_GPO_CTRL = 24'h00_0001;
  localparam logic [23:0] RST_OTHER    = 24'h00_0000;
  localparam logic [4:0]  RST_PTR      = 5'h00;

  // identity value is arbitrary, not tied to any real part
  localparam logic [23:0] IDENT_VALUE  = 24'h5A_0001;

  function automatic logic [23:0] psg_reset_value(input logic [4:0] addr);
    logic [23:0] v;
    v = RST_OTHER;
    case (addr)
      REG_CHIP_EN:  v = RST_CHIP_EN;
      REG_REFDIV:   v = RST_REFDIV;
      REG_INT:      v = RST_INT;
      REG_DRV_CTRL: v = RST_DRV_CTRL;
      REG_GPO_CTRL: v = RST_GPO_CTRL;
      default:      v = RST_OTHER;
    endcase
    return v;
  endfunction

endpackage

//--- design/psg_serial_port.sv
// Summary of operation
// - pin driver off outside addressed frames
// - enable driver when chip address is 000
// - driving starts before invalid address seen
// - reads mux readback; force bit keeps gpo
// - drive enable bit zero disables both drivers
// - separate pull-up and pull-down disables
// - hold bit keeps driver on outside frames
// - five-bit select picks gpo; default lock
// - address zero reads identity value
// - 3-bit chip, 5-bit register address
// - three wires write, four wires read
// - 24 data bits msb first, rising sample
// - then 5 register, 3 chip bits
// - respond only to chip address 000
// - latch enable rise commits shifted word
// - pin carries register chosen by pointer
// - second cycle shifts out selected data
// - only latch rise returns pin to gpo
// - readback driven during write cycles too
// - register zero bits 4:0 are pointer
// - register zero bit 5 soft resets
`timescale 1ns/1ps
module psg_serial_port
  import psg_pkg::*;
(
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // serial link from host
  input  wire logic        sclk,
  input  wire logic        serial_latch_enable,
  input  wire logic        serial_data_in,
  // readback driver onto the shared pin
  output logic             serial_readback_out,
  output logic             serial_readback_oe,
  // general purpose driver onto the same pin
  output logic             general_output_pin,
  output logic             general_output_oe,
  // general purpose sources
  input  wire logic        lock_indicator,
  input  wire logic [29:0] gp_aux
);

  ////////////////////////////////////////////////////////////////////////////
  // latch enable edge: captures the frame while sclk stands still

  logic [FRAME_BITS-1:0] shift_reg;
  logic [CNT_W-1:0]      bit_cnt_reg;
  logic [FRAME_BITS-1:0] latch_word_reg;
  logic                  latch_valid_reg;
  logic                  epoch_reg;

  always_ff @(posedge serial_latch_enable or negedge rst_b)
  begin
    if (!rst_b)
    begin
      latch_word_reg  <= '0;
      latch_valid_reg <= 1'b0;
      epoch_reg       <= 1'b0;
    end
    else
    begin
      latch_word_reg  <= shift_reg;
      latch_valid_reg <= (bit_cnt_reg == CNT_FULL);
      epoch_reg       <= ~epoch_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shift in, shift out

  logic                  epoch_seen_reg;
  logic                  first_edge;
  logic [DATA_W-1:0]     rb_word_reg;
  logic [DATA_W-1:0]     rb_shift_reg;
  logic                  frame_open_reg;
  logic                  bad_addr_reg;
  logic                  bad_addr_next;
  logic                  rb_bit_next;
  logic                  rb_oe_next;
  logic                  rb_rst_b;
  logic [NUM_REGS-1:1][DATA_W-1:0] reg_file;
  logic                  drv_en;
  logic                  force_gpo;
  logic                  hold_on;
  logic                  pu_dis;
  logic                  pd_dis;

  // epoch only toggles between frames, so it is stable at every sclk edge
  assign first_edge = (epoch_seen_reg != epoch_reg) || (bit_cnt_reg == CNT_ZERO);

  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_reg      <= '0;
      bit_cnt_reg    <= CNT_ZERO;
      epoch_seen_reg <= 1'b0;
    end
    else
    begin
      shift_reg      <= {shift_reg[FRAME_BITS-2:0], serial_data_in};
      epoch_seen_reg <= epoch_reg;
      if (first_edge)
        bit_cnt_reg <= CNT_ONE;
      else if (bit_cnt_reg != CNT_OVER)
        bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
    end
  end

  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
      rb_shift_reg <= '0;
    else if (first_edge)
      rb_shift_reg <= {rb_word_reg[DATA_W-2:0], 1'b0};
    else
      rb_shift_reg <= {rb_shift_reg[DATA_W-2:0], 1'b0};
  end

  // bits 30..32 carry the chip address; any one marks the frame foreign
  always_comb
  begin
    bad_addr_next = first_edge ? 1'b0 : bad_addr_reg;
    if (!first_edge && bit_cnt_reg >= CNT_CHIP_LO && bit_cnt_reg <= CNT_CHIP_HI
        && serial_data_in)
      bad_addr_next = 1'b1;
    rb_bit_next = first_edge ? rb_word_reg[DATA_W-1] : rb_shift_reg[DATA_W-1];
    rb_oe_next  = drv_en && !force_gpo && !bad_addr_next
                  && (rb_bit_next ? !pu_dis : !pd_dis);
  end

  // a latch enable rise drops the readback driver at once; sclk is idle then
  assign rb_rst_b = rst_b & ~serial_latch_enable;

  always_ff @(posedge sclk or negedge rb_rst_b)
  begin
    if (!rb_rst_b)
    begin
      serial_readback_out <= 1'b0;
      serial_readback_oe  <= 1'b0;
      frame_open_reg      <= 1'b0;
      bad_addr_reg        <= 1'b0;
    end
    else
    begin
      serial_readback_out <= rb_bit_next;
      serial_readback_oe  <= rb_oe_next;
      frame_open_reg      <= 1'b1;
      bad_addr_reg        <= bad_addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: synchronisers

  logic        latch_s;
  logic        frame_s;
  logic [30:0] src_s;
  logic        latch_d_reg;

  psg_sync #(.W(1)) u_latch_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (serial_latch_enable),
    .q     (latch_s)
  );

  psg_sync #(.W(1)) u_frame_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (frame_open_reg),
    .q     (frame_s)
  );

  psg_sync #(.W(31)) u_src_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({gp_aux, lock_indicator}),
    .q     (src_s)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      latch_d_reg <= 1'b0;
    else
      latch_d_reg <= latch_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: register file

  logic                  commit;
  logic [DATA_W-1:0]     wr_data;
  logic [REG_ADDR_W-1:0] wr_addr;
  logic [CHIP_ADDR_W-1:0] wr_chip;
  logic [PTR_MSB:0]      read_ptr_reg;

  assign wr_data = latch_word_reg[DATA_LSB +: DATA_W];
  assign wr_addr = latch_word_reg[REG_LSB +: REG_ADDR_W];
  assign wr_chip = latch_word_reg[CHIP_LSB +: CHIP_ADDR_W];
  // latched word is stable for two system cycles before this edge is seen
  assign commit  = latch_s && !latch_d_reg && latch_valid_reg
                   && (wr_chip == CHIP_ADDR_SELF);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      read_ptr_reg <= RST_PTR;
      for (int i = 1; i < NUM_REGS; i++)
        reg_file[i] <= psg_reset_value(5'(i));
    end
    else if (commit)
    begin
      if (wr_addr == REG_IDENT)
      begin
        if (wr_data[SOFT_RST_BIT])
        begin
          read_ptr_reg <= RST_PTR;
          for (int i = 1; i < NUM_REGS; i++)
            reg_file[i] <= psg_reset_value(5'(i));
        end
        else
          read_ptr_reg <= wr_data[PTR_MSB:0];
      end
      else
        reg_file[wr_addr] <= wr_data;
    end
  end

  // identity replaces the write-only pointer register on readback
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rb_word_reg <= IDENT_VALUE;
    else if (read_ptr_reg == REG_IDENT)
      rb_word_reg <= IDENT_VALUE;
    else
      rb_word_reg <= reg_file[read_ptr_reg];
  end

  assign drv_en    = reg_file[REG_DRV_CTRL][DRV_EN_BIT];
  assign force_gpo = reg_file[REG_GPO_CTRL][FORCE_BIT];
  assign hold_on   = reg_file[REG_GPO_CTRL][HOLD_BIT];
  assign pu_dis    = reg_file[REG_GPO_CTRL][PU_DIS_BIT];
  assign pd_dis    = reg_file[REG_GPO_CTRL][PD_DIS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // system domain: general purpose driver

  logic [31:0] gp_vec;
  logic        gpo_val_next;
  logic        gpo_oe_next;

  assign gp_vec = {src_s, 1'b0};

  // handover lags a frame edge by three system cycles; both drivers may
  // briefly overlap, a cost of keeping each driver in its own domain
  always_comb
  begin
    gpo_val_next = gp_vec[reg_file[REG_GPO_CTRL][SEL_MSB:0]];
    gpo_oe_next  = drv_en
                   && (force_gpo ? (hold_on || frame_s)
                                 : (hold_on && !frame_s))
                   && (gpo_val_next ? !pu_dis : !pd_dis);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      general_output_pin <= 1'b0;
      general_output_oe  <= 1'b0;
    end
    else
    begin
      general_output_pin <= gpo_val_next;
      general_output_oe  <= gpo_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks, system domain

  a_gpo_force_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    !drv_en |=> !general_output_oe)
    else $error("gpo driver on while drive enable is clear");

  a_gpo_halves: assert property (
    @(posedge clk) disable iff (!rst_b)
    general_output_oe |-> (general_output_pin ? !$past(pu_dis) : !$past(pd_dis)))
    else $error("gpo drives a disabled half");

  a_output_signal_select: assert property (
    @(posedge clk) disable iff (!rst_b)
    ##1 general_output_pin == $past(gp_vec[reg_file[REG_GPO_CTRL][SEL_MSB:0]]))
    else $error("gpo value not from selected source");

  a_gpo_hold_idle: assert property (
    @(posedge clk) disable iff (!rst_b)
    (drv_en && hold_on && !force_gpo && !frame_s && !pu_dis && !pd_dis)
    |=> general_output_oe)
    else $error("hold bit did not keep gpo driver on");

  a_commit_ptr: assert property (
    @(posedge clk) disable iff (!rst_b)
    (commit && wr_addr == REG_IDENT && !wr_data[SOFT_RST_BIT])
    |=> read_ptr_reg == $past(wr_data[PTR_MSB:0]))
    else $error("read pointer not loaded");

  a_soft_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    (commit && wr_addr == REG_IDENT && wr_data[SOFT_RST_BIT])
    |=> read_ptr_reg == RST_PTR && reg_file[REG_GPO_CTRL] == RST_GPO_CTRL)
    else $error("soft reset did not restore registers");

  a_short_frame: assert property (
    @(posedge clk) disable iff (!rst_b)
    (latch_s && !latch_d_reg && !latch_valid_reg) |-> !commit)
    else $error("short frame committed");

  a_ident_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    read_ptr_reg == REG_IDENT |=> rb_word_reg == IDENT_VALUE)
    else $error("identity not presented at address zero");

  ////////////////////////////////////////////////////////////////////////////
  // checks, link domain

  a_rb_msb_first: assert property (
    @(posedge sclk) disable iff (!rb_rst_b)
    first_edge |=> serial_readback_out == $past(rb_word_reg[DATA_W-1]))
    else $error("readback does not start with msb");

  a_rb_bad_addr: assert property (
    @(posedge sclk) disable iff (!rb_rst_b)
    bad_addr_reg |-> !serial_readback_oe)
    else $error("driver on after foreign chip address");

  a_rb_forced: assert property (
    @(posedge sclk) disable iff (!rb_rst_b)
    $past(force_gpo) |-> !serial_readback_oe)
    else $error("readback driven while gpo is forced");

endmodule

//--- design/psg_sync.sv
`timescale 1ns/1ps
module psg_sync
  import psg_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

//--- testbench/pll_serial_port_gpo_mux_tb_top.sv
`timescale 1ns/1ps
module pll_serial_port_gpo_mux_tb_top;
  import psg_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        lock_indicator;
  logic [29:0] gp_aux;
  wire logic   sclk;
  wire logic   serial_latch_enable;
  wire logic   serial_data_in;
  wire logic   rb_out;
  wire logic   rb_oe;
  wire logic   gp_out;
  wire logic   gp_oe;
  wire logic   line;
  int          failures;
  int          n_tests;

  assign line = rb_oe ? rb_out : (gp_oe ? gp_out : 1'bz);

  psg_serial_port u_dut (
    .clk                 (clk),
    .rst_b               (rst_b),
    .sclk                (sclk),
    .serial_latch_enable (serial_latch_enable),
    .serial_data_in      (serial_data_in),
    .serial_readback_out (rb_out),
    .serial_readback_oe  (rb_oe),
    .general_output_pin  (gp_out),
    .general_output_oe   (gp_oe),
    .lock_indicator      (lock_indicator),
    .gp_aux              (gp_aux)
  );

  psg_host_model u_host (
    .sclk                (sclk),
    .serial_latch_enable (serial_latch_enable),
    .serial_data_in      (serial_data_in),
    .line                (line),
    .serial_readback_oe  (rb_oe)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // synced sources need two clk; four leaves margin
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    check({rb_oe, gp_oe}, 32'h0000_0000);
    check(gp_out, lock_indicator);
  endtask

  task automatic t_ident();
    u_host.read_reg(REG_IDENT);
    check(u_host.rd_data, IDENT_VALUE);
    check(u_host.oe_cnt, 32'h0000_0020);
    check(rb_oe, 1'b0);
  endtask

  task automatic t_gpo();
    u_host.write_reg(REG_GPO_CTRL, 24'h00_0081);
    @(negedge clk);
    lock_indicator = 1'b0;
    settle();
    check({gp_oe, gp_out}, 32'h0000_0002);
    u_host.write_reg(REG_GPO_CTRL, 24'h00_0085);
    @(negedge clk);
    gp_aux = 30'h0000_0008;
    settle();
    check(gp_out, 1'b1);
    gp_aux = 30'h0000_0000;
    settle();
    check(gp_out, 1'b0);
    u_host.read_reg(REG_GPO_CTRL);
    check(u_host.rd_data, 24'h00_0085);
    check(u_host.oe_cnt, 32'h0000_0020);
  endtask

  task automatic t_force();
    @(negedge clk);
    lock_indicator = 1'b1;
    u_host.write_reg(REG_GPO_CTRL, 24'h00_00C1);
    u_host.read_reg(REG_IDENT);
    check(u_host.oe_cnt, 32'h0000_0000);
    check(u_host.rd_data, 24'hFF_FFFF);
  endtask

  task automatic t_halves();
    u_host.write_reg(REG_GPO_CTRL, 24'h00_0101);
    u_host.read_reg(REG_IDENT);
    check(u_host.oe_cnt, 32'h0000_001B);
    u_host.write_reg(REG_GPO_CTRL, 24'h00_0201);
    u_host.read_reg(REG_IDENT);
    check(u_host.oe_cnt, 32'h0000_0005);
    check(u_host.rd_data, IDENT_VALUE);
  endtask

  task automatic t_refuse();
    u_host.write_reg(REG_GPO_CTRL, 24'h00_0001);
    u_host.frame({24'h00_00AA, REG_REFDIV, 3'h1}, 32);
    check(u_host.oe_cnt, 32'h0000_001F);
    u_host.frame({24'h00_00AA, REG_REFDIV, 3'h0}, 31);
    u_host.read_reg(REG_REFDIV);
    check(u_host.rd_data, RST_REFDIV);
    u_host.write_reg(5'h1F, 24'hA5_5A3C);
    u_host.read_reg(5'h1F);
    check(u_host.rd_data, 24'hA5_5A3C);
  endtask

  task automatic t_drv_off();
    u_host.write_reg(REG_GPO_CTRL, 24'h00_0081);
    u_host.write_reg(REG_DRV_CTRL, 24'h00_0000);
    u_host.read_reg(REG_IDENT);
    check(u_host.oe_cnt, 32'h0000_0000);
    check(gp_oe, 1'b0);
    u_host.frame({24'h00_0020, REG_IDENT, CHIP_ADDR_SELF}, 32);
    u_host.read_reg(REG_DRV_CTRL);
    check(u_host.rd_data, RST_DRV_CTRL);
    check(u_host.oe_cnt, 32'h0000_0020);
  endtask

  ////////////////////////////////////////
  initial
  begin
    failures = 0;
    n_tests = 0;
    rst_b = 1'b0;
    lock_indicator = 1'b1;
    gp_aux = 30'h0000_0000;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    settle();
    t_reset();
    t_ident();
    t_gpo();
    t_force();
    t_halves();
    t_refuse();
    t_drv_off();
    give_verdict();
  end

  // cuts a hang short
  initial
  begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule

//--- testbench/psg_host_model.sv
`timescale 1ns/1ps
module psg_host_model
  import psg_pkg::*;
(
  // link to device
  output logic      sclk,
  output logic      serial_latch_enable,
  output logic      serial_data_in,
  // shared pin level and readback enable
  input  wire logic line,
  input  wire logic serial_readback_oe
);
  logic [23:0] rd_data;
  logic [5:0]  oe_cnt;

  initial
  begin
    sclk = 1'b0;
    serial_latch_enable = 1'b0;
    serial_data_in = 1'b0;
    rd_data = 24'h00_0000;
    oe_cnt = 6'h00;
  end

  ////////////////////////////////////////
  // clock stands low between frames; undriven pin reads as 0
  task automatic frame(input logic [31:0] w, input int n);
    rd_data = 24'h00_0000;
    oe_cnt = 6'h00;
    for (int i = 0; i < n; i++)
    begin
      serial_data_in = w[31 - i];
      #3 sclk = 1'b1;
      #2;
      if (i < DATA_W)
        rd_data[23 - i] = (line === 1'b1);
      if (serial_readback_oe === 1'b1)
        oe_cnt = oe_cnt + 6'h01;
      #1 sclk = 1'b0;
    end
    serial_data_in = ~serial_data_in;
    #3 serial_latch_enable = 1'b1;
    // latch held and gap kept long enough for the clk-side commit
    #125 serial_latch_enable = 1'b0;
    #175;
  endtask

  task automatic write_reg(input logic [4:0] a, input logic [23:0] d);
    frame({d, a, CHIP_ADDR_SELF}, 32);
  endtask

  task automatic read_reg(input logic [4:0] a);
    frame({19'h0_0000, a, REG_IDENT, CHIP_ADDR_SELF}, 32);
    frame({19'h0_0000, a, REG_IDENT, CHIP_ADDR_SELF}, 32);
  endtask
endmodule
